// *** include/gain_filter_cfg_pkg.sv ***
/*
 package of constants for the serial gain and filter configuration port:
 control word layout, apb register offsets and reset values.
 assumes nothing beyond a systemverilog compiler.
*/
package gain_filter_cfg_pkg;

	// ============================================================
	// control word layout, bit 0 is the first data bit shifted
	localparam int unsigned CW_W       = 15;
	localparam int unsigned CNT_W      = 4;
	localparam logic [3:0]  BITS_LAST  = 4'hf;
	localparam int unsigned FILT_LSB   = 9;
	localparam int unsigned FILT_W     = 6;
	localparam int unsigned PWR_BIT    = 8;
	localparam int unsigned G1_LSB     = 6;
	localparam int unsigned G2_LSB     = 4;
	localparam int unsigned G3_LSB     = 2;
	localparam int unsigned GAIN_W     = 2;
	localparam int unsigned POST_BIT   = 1;
	localparam int unsigned OFS_BIT    = 0;
	localparam logic [5:0]  FILT_BYPASS_CODE = 6'h00;
	localparam logic [14:0] CW_RESET   = 15'h0000;

	// ============================================================
	// apb register map
	localparam int unsigned ADDR_W      = 12;
	localparam logic [11:0] OFS_WORD    = 12'h000;
	localparam logic [11:0] OFS_CONFIG  = 12'h004;
	localparam logic [11:0] OFS_STATUS  = 12'h008;
	localparam int unsigned CFG_WR_BIT  = 0;
	localparam int unsigned CFG_RD_BIT  = 1;
	localparam logic [1:0]  CFG_RESET   = 2'h3;
	localparam int unsigned ST_ACT_BIT  = 0;
	localparam int unsigned ST_REJ_BIT  = 1;
	localparam int unsigned ST_CNT_LSB  = 8;
	localparam int unsigned WCNT_W      = 8;

	// ============================================================
	// frame sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SELECT,
		ST_WRITE,
		ST_READ,
		ST_IGNORE
	} frame_state_t;

endpackage

// *** core/pin_sync.sv ***
/*
 two flip-flop synchroniser for a group of independent pin levels.
 assumes each bit is a level that is stable for several pclk periods.
*/
`timescale 1ns/1ns
module pin_sync #(
	parameter int unsigned WIDTH = 3
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// ============================================================
	// first stage is read by the second stage only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// *** core/control_word_decode.sv ***
/*
 splits the applied control word into registered control fields for the
 analog chain. assumes the word changes only as a whole, in one cycle.
*/
`timescale 1ns/1ns
module control_word_decode (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [14:0] word,
	output logic      [5:0]  filter_code,
	output logic             filter_bypass,
	output logic             power_high,
	output logic      [1:0]  first_gain_code,
	output logic      [1:0]  second_gain_stage_code,
	output logic      [1:0]  third_gain_stage_code,
	output logic             post_gain_high,
	output logic             offset_loop_off
);

	logic [5:0] code;

	assign code = word[gain_filter_cfg_pkg::FILT_LSB +: gain_filter_cfg_pkg::FILT_W];

	// ============================================================
	// every field moves on the same edge so the chain never sees a mix
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			filter_code            <= '0;
			filter_bypass          <= 1'b1;
			power_high             <= 1'b0;
			first_gain_code        <= '0;
			second_gain_stage_code <= '0;
			third_gain_stage_code  <= '0;
			post_gain_high         <= 1'b0;
			offset_loop_off        <= 1'b0;
		end
		else
		begin
			filter_code            <= code;
			filter_bypass          <= (code == gain_filter_cfg_pkg::FILT_BYPASS_CODE);
			power_high             <= word[gain_filter_cfg_pkg::PWR_BIT];
			first_gain_code        <= word[gain_filter_cfg_pkg::G1_LSB +: 2];
			second_gain_stage_code <= word[gain_filter_cfg_pkg::G2_LSB +: 2];
			third_gain_stage_code  <= word[gain_filter_cfg_pkg::G3_LSB +: 2];
			post_gain_high         <= word[gain_filter_cfg_pkg::POST_BIT];
			offset_loop_off        <= word[gain_filter_cfg_pkg::OFS_BIT];
		end
	end

endmodule

// *** core/serial_gain_filter_config_port.sv ***
/*
 serial configuration port of a dual channel filter and gain chain, with
 an apb slave for software readback and gating.
 assumes the serial pins come from another clock domain and toggle no
 faster than a few pclk periods; pclk runs at 100 mhz.
*/
// Operation
// - the first serial clock rise after the strobe falls samples data: one write, zero read.
// - a write captures the next fifteen bits on rising edges, lsb first.
// - the strobe rising after a write applies the whole new word at once.
// - a read shifts the stored word out lsb first on the next fifteen falling edges.
// - the strobe rising ends a read and releases the output pin.
// - one fifteen bit control word holds corner, gains, power mode and offset loop bit.
// - the corner field selects 1 mhz to 63 mhz in 1 mhz steps.
// - bypass disables the filters, routes around them and saves power.
// - the gains after the second and third stages are selectable among four steps.
// - one word bit switches the dc offset loop off.
// - one word bit selects power mode, updated with the rest.
// - the corner field is the corner in mhz as unsigned binary.
// - a corner field of zero selects filter bypass.
`timescale 1ns/1ns
module serial_gain_filter_config_port (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        frame_strobe,
	input  wire logic        serial_clk,
	input  wire logic        serial_data,
	output logic             serial_out_reset_pin_o,
	output logic             serial_out_reset_pin_oe,
	output logic      [5:0]  filter_code,
	output logic             filter_bypass,
	output logic             power_high,
	output logic      [1:0]  first_gain_code,
	output logic      [1:0]  second_gain_stage_code,
	output logic      [1:0]  third_gain_stage_code,
	output logic             post_gain_high,
	output logic             offset_loop_off
);

	// ============================================================
	// pin synchronisation and edge detection

	logic [2:0] pins_s;
	logic       strobe_s;
	logic       sclk_s;
	logic       data_s;
	logic       sclk_prev_q;
	logic       strobe_prev_q;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       strobe_rise;

	pin_sync #(
		.WIDTH    (3)
	) u_pin_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({~frame_strobe, serial_clk, serial_data}),
		.sync_out (pins_s)
	);

	// strobe passes inverted so the zero reset of the stages matches its idle
	// high level and no false frame follows reset
	assign strobe_s = ~pins_s[2];
	assign sclk_s   = pins_s[1];
	assign data_s   = pins_s[0];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_prev_q   <= 1'b0;
			strobe_prev_q <= 1'b1;
		end
		else
		begin
			sclk_prev_q   <= sclk_s;
			strobe_prev_q <= strobe_s;
		end
	end

	assign sclk_rise   = sclk_s & ~sclk_prev_q;
	assign sclk_fall   = ~sclk_s & sclk_prev_q;
	assign strobe_rise = strobe_s & ~strobe_prev_q;

	// ============================================================
	// frame sequencer

	gain_filter_cfg_pkg::frame_state_t state_q;

	logic [3:0]  bit_cnt_q;
	logic [14:0] shift_in_q;
	logic [14:0] word_q;
	logic [1:0]  cfg_q;
	logic        rejected_q;
	logic [7:0]  write_cnt_q;
	logic        bits_full;
	logic        apply_word;

	assign bits_full  = (bit_cnt_q == gain_filter_cfg_pkg::BITS_LAST);
	// a short write frame is dropped so a half written word never lands
	assign apply_word = strobe_rise && (state_q == gain_filter_cfg_pkg::ST_WRITE) && bits_full;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= gain_filter_cfg_pkg::ST_IDLE;
		end
		else if (strobe_s)
		begin
			state_q <= gain_filter_cfg_pkg::ST_IDLE;
		end
		else
		begin
			case (state_q)
				gain_filter_cfg_pkg::ST_IDLE:
				begin
					state_q <= gain_filter_cfg_pkg::ST_SELECT;
				end
				gain_filter_cfg_pkg::ST_SELECT:
				begin
					if (sclk_rise)
					begin
						if (data_s)
							state_q <= cfg_q[gain_filter_cfg_pkg::CFG_WR_BIT] ?
								gain_filter_cfg_pkg::ST_WRITE :
								gain_filter_cfg_pkg::ST_IGNORE;
						else
							state_q <= cfg_q[gain_filter_cfg_pkg::CFG_RD_BIT] ?
								gain_filter_cfg_pkg::ST_READ :
								gain_filter_cfg_pkg::ST_IGNORE;
					end
				end
				gain_filter_cfg_pkg::ST_WRITE,
				gain_filter_cfg_pkg::ST_READ,
				gain_filter_cfg_pkg::ST_IGNORE:
				begin
					state_q <= state_q;
				end
				default:
				begin
					state_q <= gain_filter_cfg_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// bit counter: rising edges in a write, falling edges in a read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bit_cnt_q <= '0;
		end
		else if (state_q != gain_filter_cfg_pkg::ST_WRITE &&
			state_q != gain_filter_cfg_pkg::ST_READ)
		begin
			bit_cnt_q <= '0;
		end
		else if (!bits_full && !strobe_s &&
			((state_q == gain_filter_cfg_pkg::ST_WRITE && sclk_rise) ||
			(state_q == gain_filter_cfg_pkg::ST_READ && sclk_fall)))
		begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
		end
	end

	// ============================================================
	// write path

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			shift_in_q <= '0;
		end
		else if (state_q == gain_filter_cfg_pkg::ST_WRITE && sclk_rise && !bits_full && !strobe_s)
		begin
			shift_in_q[bit_cnt_q] <= data_s;
		end
	end

	// no reset value is defined for the word; zero means filter bypass
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			word_q <= gain_filter_cfg_pkg::CW_RESET;
		end
		else if (apply_word)
		begin
			word_q <= shift_in_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rejected_q  <= 1'b0;
			write_cnt_q <= '0;
		end
		else if (strobe_rise && state_q == gain_filter_cfg_pkg::ST_WRITE)
		begin
			rejected_q  <= !bits_full;
			write_cnt_q <= bits_full ? write_cnt_q + 8'h01 : write_cnt_q;
		end
	end

	// ============================================================
	// read path: pin is driven only between the select bit and frame end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			serial_out_reset_pin_o  <= 1'b0;
			serial_out_reset_pin_oe <= 1'b0;
		end
		else if (strobe_s || state_q != gain_filter_cfg_pkg::ST_READ)
		begin
			serial_out_reset_pin_o  <= 1'b0;
			serial_out_reset_pin_oe <= 1'b0;
		end
		else if (sclk_fall && !bits_full)
		begin
			serial_out_reset_pin_o  <= word_q[bit_cnt_q];
			serial_out_reset_pin_oe <= 1'b1;
		end
	end

	control_word_decode u_decode (
		.pclk                   (pclk),
		.presetn                (presetn),
		.word                   (word_q),
		.filter_code            (filter_code),
		.filter_bypass          (filter_bypass),
		.power_high             (power_high),
		.first_gain_code        (first_gain_code),
		.second_gain_stage_code (second_gain_stage_code),
		.third_gain_stage_code  (third_gain_stage_code),
		.post_gain_high         (post_gain_high),
		.offset_loop_off        (offset_loop_off)
	);

	// ============================================================
	// apb slave, one wait state on every access

	logic access_first;
	logic access_done;

	function automatic logic addr_hit(input logic [11:0] addr);
		addr_hit = (addr == gain_filter_cfg_pkg::OFS_WORD) ||
			(addr == gain_filter_cfg_pkg::OFS_CONFIG) ||
			(addr == gain_filter_cfg_pkg::OFS_STATUS);
	endfunction

	function automatic logic [31:0] read_mux(input logic [11:0] addr);
		logic [31:0] v;
		v = '0;
		case (addr)
			gain_filter_cfg_pkg::OFS_WORD:
				v[14:0] = word_q;
			gain_filter_cfg_pkg::OFS_CONFIG:
				v[1:0] = cfg_q;
			gain_filter_cfg_pkg::OFS_STATUS:
			begin
				v[gain_filter_cfg_pkg::ST_ACT_BIT] = !strobe_s;
				v[gain_filter_cfg_pkg::ST_REJ_BIT] = rejected_q;
				v[gain_filter_cfg_pkg::ST_CNT_LSB +: 8] = write_cnt_q;
			end
			default:
				v = '0;
		endcase
		read_mux = v;
	endfunction

	assign access_first = psel && penable && !pready;
	assign access_done  = psel && penable && pready;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= access_first;
			prdata  <= access_first && !pwrite ? read_mux(paddr) : '0;
			pslverr <= access_first && !addr_hit(paddr);
		end
	end

	// writes land on the edge where the master sees pready high
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_q <= gain_filter_cfg_pkg::CFG_RESET;
		end
		else if (access_done && pwrite && paddr == gain_filter_cfg_pkg::OFS_CONFIG)
		begin
			cfg_q <= pwdata[1:0];
		end
	end

endmodule

// *** bench/serial_gain_filter_config_port_checker.sv ***
/*
 concurrent checks on the serial configuration port.
 bound to the top module; sees only its ports.
*/
`timescale 1ns/1ns
module cfg_port_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic        frame_strobe,
	input wire logic        serial_out_reset_pin_oe,
	input wire logic [5:0]  filter_code,
	input wire logic        filter_bypass,
	input wire logic        power_high
);
	// ========================================
	// strobe high time, saturating
	logic [3:0] hi_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hi_q <= 4'h0;
		else if (!frame_strobe)
			hi_q <= 4'h0;
		else if (hi_q != 4'hf)
			hi_q <= hi_q + 4'h1;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ========================================
	// assertions
	bypass_code_a:
		assert property (filter_bypass == (filter_code == 6'h00))
		else $error("bypass flag disagrees with corner");
	idle_hold_a:
		assert property (hi_q == 4'hf |=> $stable(filter_code) && $stable(power_high))
		else $error("word moved with strobe idle");
	apply_late_a:
		assert property ($changed(filter_code) || $changed(power_high) |->
			$past(frame_strobe, 3))
		else $error("word applied before strobe rose");
	read_release_a:
		assert property ($rose(frame_strobe) |-> ##[1:6] !serial_out_reset_pin_oe)
		else $error("pin still driven after frame");
	drive_frame_a:
		assert property ($rose(serial_out_reset_pin_oe) |-> !frame_strobe)
		else $error("pin driven outside a frame");
	apb_answer_a:
		assert property (psel && penable && !pready |-> ##[1:2] pready)
		else $error("no apb answer");
	err_ready_a:
		assert property (pslverr |-> pready)
		else $error("error without ready");
	rdata_idle_a:
		assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
endmodule

bind serial_gain_filter_config_port cfg_port_checker chk (
	.pclk                    (pclk),
	.presetn                 (presetn),
	.psel                    (psel),
	.penable                 (penable),
	.pready                  (pready),
	.pslverr                 (pslverr),
	.prdata                  (prdata),
	.frame_strobe            (frame_strobe),
	.serial_out_reset_pin_oe (serial_out_reset_pin_oe),
	.filter_code             (filter_code),
	.filter_bypass           (filter_bypass),
	.power_high              (power_high)
);

// *** bench/serial_host_model.sv ***
/*
 behavioural host driving the three-wire configuration link.
 assumes the caller spaces frames; the link clock idles low.
*/
`timescale 1ns/1ns
module serial_host_model (
	input  wire logic pclk,
	input  wire logic pin_o,
	input  wire logic pin_oe,
	output logic      frame_strobe,
	output logic      serial_clk,
	output logic      serial_data
);
	initial
	begin
		frame_strobe = 1'b1;
		serial_clk = 1'b0;
		serial_data = 1'b0;
	end
	// ========================================
	// half period in ns, counted in pclk edges
	task automatic hold(input int hp);
		repeat (hp / 10) @(posedge pclk);
	endtask
	// ========================================
	// one frame; hp is the half period, 80 for a 160 ns clock
	task automatic frame(input logic wr, input logic [31:0] w, input int n,
		input int hp, output logic [14:0] r);
		r = 15'h0;
		@(posedge pclk);
		frame_strobe <= 1'b0;
		hold(hp);
		serial_data <= wr;
		hold(hp);
		serial_clk <= 1'b1;
		for (int i = 0; i < n; i++)
		begin
			hold(hp);
			serial_clk  <= 1'b0;
			serial_data <= w[i];
			hold(hp);
			// undriven pin has no pull: see the inverse level
			r[i % 15] = pin_oe ? pin_o : ~pin_o;
			serial_clk <= 1'b1;
		end
		hold(hp);
		serial_clk  <= 1'b0;
		serial_data <= ~serial_data;
		hold(hp);
		frame_strobe <= 1'b1;
		hold(hp);
	endtask
	// ========================================
	// clock and data activity with the strobe high
	task automatic noise(input logic [7:0] pat);
		for (int i = 0; i < 8; i++)
		begin
			repeat (8) @(posedge pclk);
			serial_data <= pat[i];
			serial_clk  <= ~serial_clk;
		end
	endtask
endmodule

// *** bench/serial_gain_filter_config_port_tb.sv ***
/*
 self-checking bench of the serial configuration port.
 assumes the host model and checker files are compiled first.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, a, e); end end
module serial_gain_filter_config_port_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic        strobe, sclk, sdata, pin_o, pin_oe, byp;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, w;
	logic [14:0] rb;
	wire  [14:0] outs;
	logic [5:0]  corner [6] = '{6'h00, 6'h01, 6'h1f, 6'h20, 6'h3f, 6'h2a};
	int          fail_count, n_compared, exp_w, cfg, cyc;

	serial_gain_filter_config_port dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .frame_strobe(strobe),
		.serial_clk(sclk), .serial_data(sdata), .serial_out_reset_pin_o(pin_o),
		.serial_out_reset_pin_oe(pin_oe), .filter_code(outs[14:9]),
		.filter_bypass(byp), .power_high(outs[8]), .first_gain_code(outs[7:6]),
		.second_gain_stage_code(outs[5:4]), .third_gain_stage_code(outs[3:2]),
		.post_gain_high(outs[1]), .offset_loop_off(outs[0])
	);
	serial_host_model host (
		.pclk(pclk), .pin_o(pin_o), .pin_oe(pin_oe), .frame_strobe(strobe),
		.serial_clk(sclk), .serial_data(sdata)
	);

	always #5 pclk = ~pclk;
	// ========================================
	// hang guard
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			fail_count++;
			end_sim();
		end
	end
	// ========================================
	// tasks
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, wr_en, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		// only the hang guard ends this wait if pready never rises
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
		if (wr_en && a == 12'h004)
			cfg = d[1:0];
	endtask
	task automatic wr(input logic [31:0] v, input int n, input int hp);
		if (v[14:9] > 6'h1f)
			v[8] = 1'b1;
		host.frame(1'b1, v, n, hp, rb);
		if (n >= 15 && cfg[0])
			exp_w = v[14:0];
	endtask
	task automatic check_word();
		repeat (8) @(posedge pclk);
		`CHK(outs, exp_w[14:0])
		`CHK(byp, exp_w[14:9] == 6'h00)
		apb(1'b0, 12'h000, 32'h0);
		`CHK({er, rd}, {1'b0, exp_w})
		host.frame(1'b0, 32'h0, 15, 80, rb);
		if (cfg[1])
			`CHK(rb, exp_w[14:0])
	endtask
	// ========================================
	// main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pclk = 1'b0;
		cfg = 3;
		w = $urandom(54);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		`CHK(rd, 32'h3)
		check_word();
		$display("test reset done");
		foreach (corner[k])
		begin
			w = {corner[k], k[0], k[1:0], k[1:0], k[1:0], k[1], ~k[0]};
			wr(w, 15, 80);
			check_word();
		end
		repeat (4)
		begin
			wr($urandom(), 15, 80);
			check_word();
		end
		$display("test words done");
		wr($urandom(), 10, 80);
		apb(1'b0, 12'h008, 32'h0);
		`CHK(rd[1], 1'b1)
		check_word();
		wr($urandom(), 18, 80);
		check_word();
		$display("test bit counts done");
		host.noise($urandom());
		check_word();
		$display("test idle noise done");
		host.frame(1'b0, 32'h0, 5, 80, rb);
		`CHK(pin_oe, 1'b0)
		`CHK(rb[4:0], exp_w[4:0])
		$display("test read abort done");
		apb(1'b0, 12'h00c, 32'h0);
		`CHK({er, rd}, 33'h100000000)
		apb(1'b1, 12'h000, $urandom());
		apb(1'b1, 12'h004, 32'h0);
		wr($urandom(), 15, 80);
		check_word();
		apb(1'b1, 12'h004, 32'h3);
		check_word();
		$display("test apb done");
		end_sim();
	end
endmodule
